// ### dv/ctrl_model.sv
// Controller-side model: drives write beats and resolves the shared data and flag wires.
`timescale 1ns/1ps

module ctrl_model
  import mask_inv_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic [DQ_W-1:0]  dqOut,
  input  wire logic [DQ_W-1:0]  dqOe_n,
  input  wire logic [LANES-1:0] byteFlagOut_n,
  input  wire logic [LANES-1:0] byteFlagOe_n,
  output logic [DQ_W-1:0]       dqIn,
  output logic [LANES-1:0]      byteFlagIn_n,
  output logic                  wrBeatIn,
  output logic [DQ_W-1:0]       dqWire,
  output logic [LANES-1:0]      flagWire_n
);
  logic [DQ_W-1:0]  drvData  = '0;
  logic [DQ_W-1:0]  lastData = '0;
  logic [LANES-1:0] drvFlag  = '1;
  logic             drvOn    = 1'b0;

  // A released data line shows the inverse of its last value, so stale data never matches.
  assign dqWire = (~dqOe_n & dqOut) | (dqOe_n & (drvOn ? drvData : ~lastData));
  // Flag lines are terminated high, so an undriven flag reads as not set.
  assign flagWire_n = (~byteFlagOe_n & byteFlagOut_n) |
                      (byteFlagOe_n & (drvOn ? drvFlag : {LANES{1'b1}}));
  assign dqIn = dqWire;
  assign byteFlagIn_n = flagWire_n;
  assign wrBeatIn = drvOn;

  // One write beat with one flag bit per byte lane; a gap before it models a slow controller.
  task automatic sendBeat(input logic [DQ_W-1:0] dv, input logic [LANES-1:0] fv, input int gap);
    if (gap > 0) begin
      drvOn <= 1'b0;
      repeat (gap) @(posedge sys_clk);
    end
    drvData <= dv;
    lastData <= dv;
    drvFlag <= fv;
    drvOn <= 1'b1;
    @(posedge sys_clk);
  endtask

  // Release the bus after a burst.
  task automatic idle();
    drvOn <= 1'b0;
  endtask
endmodule

// ### dv/tb.sv
// Self-checking testbench for the byte mask and inversion codec.
`timescale 1ns/1ps

module tb
  import mask_inv_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              arst_n, wrBeatIn, flagRxOn, coreWrValid, coreRdValid;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [DQ_W-1:0]   dqIn, dqOut, dqOe_n, coreWrData, coreRdData, dqWire, d;
  logic [LANES-1:0]  byteFlagIn_n, byteFlagOut_n, byteFlagOe_n, coreWrByteEn, flagWire_n, f;
  logic [RTT_W-1:0]  dqsRtt, termStrobeRtt;
  logic              maskOn, winvOn, rinvOn;
  logic              rdSeen = 1'b0;
  logic [17:0]       wrExp, wrQ[$];
  logic [18:0]       rdExp, rdQ[$];
  int                mismatches = 0, numChecks = 0, cycles = 0, beats = 0;

  always #5 sys_clk = ~sys_clk;

  byte_mask_inversion_codec byte_mask_inversion_codec_inst (
    .sys_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .dqIn, .dqOut, .dqOe_n, .wrBeatIn, .byteFlagIn_n,
    .byteFlagOut_n, .byteFlagOe_n, .flagRxOn, .dqsRtt, .termStrobeRtt, .coreWrData,
    .coreWrByteEn, .coreWrValid, .coreRdData, .coreRdValid);

  ctrl_model ctrl_model_inst (
    .sys_clk, .dqOut, .dqOe_n, .byteFlagOut_n, .byteFlagOe_n, .dqIn, .byteFlagIn_n,
    .wrBeatIn, .dqWire, .flagWire_n);

  // Count every comparison and report a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Single place where the run ends.
  task automatic results();
    if (mismatches == 0 && numChecks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Reference for one write beat: {byte enables, stored data}.
  function automatic logic [17:0] expWr(logic [15:0] dv, logic [1:0] fv);
    logic [17:0] r;
    r = {2'b11, dv};
    for (int l = 0; l < LANES; l++) begin
      if (winvOn && !fv[l]) r[8*l +: 8] = ~dv[8*l +: 8];
      if (maskOn && !fv[l]) r[16+l] = 1'b0;
    end
    return r;
  endfunction

  // Reference for one read beat: {flags driven, flag levels, wire data}.
  function automatic logic [18:0] expRd(logic [15:0] dv);
    logic [18:0] r;
    r = {rinvOn, 2'b11, dv};
    for (int l = 0; l < LANES; l++) begin
      if (rinvOn && (8 - $countones(dv[8*l +: 8])) > 4) begin
        r[8*l +: 8] = ~dv[8*l +: 8];
        r[16+l] = 1'b0;
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] expStatus();
    return {25'h0, 3'(beats % 8), 1'b0, rinvOn, maskOn | winvOn, !(maskOn && winvOn)};
  endfunction

  // Bus master: address and data offered together, each released when taken.
  task automatic axiWr(input logic [7:0] a, input logic [31:0] wd, input logic [1:0] er);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    chk(32'(s_axi_bresp), 32'(er), "write response");
  endtask

  task automatic axiRd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, ed, "register read");
    chk(32'(s_axi_rresp), 32'(er), "read response");
  endtask

  // Back-to-back read beats; the first holds one byte with five zeros and one with four.
  task automatic rdBurst(input int n);
    for (int i = 0; i < n; i++) begin
      d = (i == 0) ? 16'h070F : DQ_W'($urandom);
      rdQ.push_back(expRd(d));
      coreRdData <= d;
      coreRdValid <= 1'b1;
      @(posedge sys_clk);
    end
    coreRdValid <= 1'b0;
    while (rdQ.size() != 0) @(posedge sys_clk);
  endtask

  // Compare every core write beat and every read beat on the wires with the reference.
  always @(posedge sys_clk) begin
    rdSeen <= coreRdValid;
    if (coreWrValid === 1'b1) begin
      wrExp = (wrQ.size() != 0) ? wrQ.pop_front() : 18'h0;
      chk(32'({coreWrByteEn, coreWrData}), 32'(wrExp), "write beat");
    end
    if (rdSeen === 1'b1) begin
      rdExp = (rdQ.size() != 0) ? rdQ.pop_front() : 19'h0;
      chk(32'(dqOe_n), 32'h0, "read data enable");
      chk(32'(dqWire), 32'(rdExp[15:0]), "read data");
      chk(32'(byteFlagOe_n), rdExp[18] ? 32'h0 : 32'h3, "flag enable");
      chk(32'(flagWire_n), 32'(rdExp[17:16]), "flag level");
      chk(32'(termStrobeRtt), 32'h0, "termination setting");
    end
  end

  // Watchdog: a hang counts as a mismatch; the whole run needs well under this.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    void'($urandom(55986));
    arst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {coreRdData, coreRdValid, dqsRtt} = '0;
    {maskOn, winvOn, rinvOn} = '0;
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    axiRd(ADDR_MR1, 32'h0, RESP_OKAY);
    axiRd(ADDR_MR5, 32'h0, RESP_OKAY);
    axiRd(ADDR_STATUS, 32'h1, RESP_OKAY);
    axiWr(ADDR_MR1, 32'hFFFF_FFFF, RESP_OKAY);
    axiRd(ADDR_MR1, {16'h0, MR1_WR_MASK}, RESP_OKAY);
    axiWr(8'h0C, 32'h0000_1C00, RESP_SLVERR);
    axiRd(8'h0C, 32'h0, RESP_SLVERR);
    axiWr(ADDR_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    // Every combination of read inversion, write inversion and mask, the illegal ones too.
    for (int m = 0; m < 8; m++) begin
      {rinvOn, winvOn, maskOn} = 3'(m);
      axiWr(ADDR_MR5, 32'(m) << MR5_MASK_BIT, RESP_OKAY);
      axiRd(ADDR_MR5, 32'(m) << MR5_MASK_BIT, RESP_OKAY);
      axiRd(ADDR_STATUS, expStatus(), RESP_OKAY);
      chk(32'(flagRxOn), 32'(maskOn | winvOn), "flag receiver");
      dqsRtt <= RTT_W'($urandom);
      for (int i = 0; i < BURST_LEN; i++) begin
        d = DQ_W'($urandom);
        f = LANES'($urandom);
        wrQ.push_back(expWr(d, f));
        ctrl_model_inst.sendBeat(d, f, (m % 3 == 1 && i == 3) ? 2 : 0);
      end
      ctrl_model_inst.idle();
      while (wrQ.size() != 0) @(posedge sys_clk);
      rdBurst(BURST_LEN);
      beats += 2 * BURST_LEN;
    end
    rdBurst(3);
    beats += 3;
    axiRd(ADDR_STATUS, expStatus(), RESP_OKAY);
    results();
  end
endmodule

// ### hw/byte_mask_inversion_codec.sv
// Byte write mask and bus inversion codec for a x16 DRAM data interface.
//
// Behaviour
// - Mask and inversion exist only in x8 and x16 parts, and this x16 part provides both.
// - The termination strobe function belongs to x8 parts only.
// - Each byte lane has one shared two-way flag pin that is active low.
// - Enables come from mode register bits: MR1 A11 termination, MR5 A12/A11/A10 read inv/write inv/mask.
// - With mask and write inversion both off the flag receiver is off and its level ignored.
// - On reads only inversion applies, and with it off the flag driver is off.
// - With termination enabled all mask and inversion functions are off.
// - With termination enabled the flag pin is never driven.
// - With termination enabled its pin pair uses the data strobe termination setting.
// - With mask on a byte is dropped when its flag sampled low and written when high.
// - With write inversion on a byte is inverted when its flag sampled low, else kept.
// - With read inversion on a byte with more than four zeros is inverted and its flag driven low.
// - The low byte pairs with the low lane flag and the high byte with the high one, per beat.
// - On a x8 read each beat's flag belongs to that beat's byte.
// - Only the documented enable combinations are legal and the status reports legality.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps

module byte_mask_inversion_codec
  import mask_inv_pkg::*;
(
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  // AXI4-Lite register slave.
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Data pins, each two-way pin split into input, output and active-low enable.
  input  wire logic [DQ_W-1:0]     dqIn,
  output logic [DQ_W-1:0]          dqOut,
  output logic [DQ_W-1:0]          dqOe_n,
  input  wire logic                wrBeatIn,
  // Shared lane flag pins: bit 0 low lane, bit 1 high lane.
  input  wire logic [LANES-1:0]    byteFlagIn_n,
  output logic [LANES-1:0]         byteFlagOut_n,
  output logic [LANES-1:0]         byteFlagOe_n,
  output logic                     flagRxOn,
  // Termination settings for the strobe pairs.
  input  wire logic [RTT_W-1:0]    dqsRtt,
  output logic [RTT_W-1:0]         termStrobeRtt,
  // Core side: write beats out, read beats in.
  output logic [DQ_W-1:0]          coreWrData,
  output logic [LANES-1:0]         coreWrByteEn,
  output logic                     coreWrValid,
  input  wire logic [DQ_W-1:0]     coreRdData,
  input  wire logic                coreRdValid
);

  // Read encoder decision for one byte: more zero bits than the limit; shared with its check.
  function automatic logic needInvert(input logic [BYTE_W-1:0] b);
    return (BYTE_W - $countones(b)) > int'(ZERO_LIMIT);
  endfunction

  logic [MR_W-1:0]       mr1_reg;
  logic [MR_W-1:0]       mr5_reg;
  logic                  awready_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  arready_reg;
  logic                  rvalid_reg;
  logic [1:0]            rresp_reg;
  logic [31:0]           rdata_reg;
  logic [DQ_W-1:0]       dqSync1_reg;
  logic [DQ_W-1:0]       dqSync2_reg;
  logic [LANES-1:0]      flagSync1_reg;
  logic [LANES-1:0]      flagSync2_reg;
  logic                  beatSync1_reg;
  logic                  beatSync2_reg;
  logic [DQ_W-1:0]       wrData_reg;
  logic [LANES-1:0]      wrByteEn_reg;
  logic                  wrValid_reg;
  logic [DQ_W-1:0]       dqOut_reg;
  logic [DQ_W-1:0]       dqOe_reg;
  logic [LANES-1:0]      flagOut_reg;
  logic [LANES-1:0]      flagOe_reg;
  logic                  rxOn_reg;
  logic [RTT_W-1:0]      termRtt_reg;
  logic [BEAT_W-1:0]     beatIdx_reg;
  logic                  termOn;
  logic                  maskOn;
  logic                  wrInvOn;
  logic                  rdInvOn;
  logic                  legalMode;
  logic                  wrTake;
  logic                  rdTake;
  logic [31:0]           wrBitMask;

  // Enables decoded from the mode register images.
  assign termOn  = mr1_reg[MR1_TERM_BIT];
  assign maskOn  = mr5_reg[MR5_MASK_BIT]  & ~termOn;
  assign wrInvOn = mr5_reg[MR5_WRINV_BIT] & ~termOn;
  assign rdInvOn = mr5_reg[MR5_RDINV_BIT] & ~termOn;

  // Legal combinations: mask and write inversion exclusive, termination alone.
  assign legalMode = termOn ? ~(mr5_reg[MR5_MASK_BIT] | mr5_reg[MR5_WRINV_BIT]
                                | mr5_reg[MR5_RDINV_BIT])
                            : ~(mr5_reg[MR5_MASK_BIT] & mr5_reg[MR5_WRINV_BIT]);

  // A write is taken only with address and data both present, so order is free.
  assign wrTake = s_axi_awvalid & s_axi_wvalid & ~awready_reg & ~bvalid_reg;
  assign rdTake = s_axi_arvalid & ~arready_reg & ~rvalid_reg;

  // Byte enables of the write strobe widened to bit lanes.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wrBitMask[i*8 +: 8] = {8{s_axi_wstrb[i]}};
    end
  end

  // Write address and data channel ready, one cycle wide.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awready_reg <= 1'b0;
    end else begin
      awready_reg <= wrTake;
    end
  end

  // Write response; holds until the master takes it.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (awready_reg) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (s_axi_awaddr == ADDR_MR1 || s_axi_awaddr == ADDR_MR5
                     || s_axi_awaddr == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Mode register images. The termination bit never sticks in this x16 part.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mr1_reg <= MR_RESET;
      mr5_reg <= MR_RESET;
    end else if (awready_reg) begin
      if (s_axi_awaddr == ADDR_MR1) begin
        mr1_reg <= (mr1_reg & ~(wrBitMask[MR_W-1:0] & MR1_WR_MASK))
                 | (s_axi_wdata[MR_W-1:0] & wrBitMask[MR_W-1:0] & MR1_WR_MASK);
      end
      if (s_axi_awaddr == ADDR_MR5) begin
        mr5_reg <= (mr5_reg & ~(wrBitMask[MR_W-1:0] & MR5_WR_MASK))
                 | (s_axi_wdata[MR_W-1:0] & wrBitMask[MR_W-1:0] & MR5_WR_MASK);
      end
    end
  end

  // Read channel; status shows legality, pin state and the beat position.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      arready_reg <= rdTake;
      if (arready_reg) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= RESP_OKAY;
        rdata_reg  <= 32'h0000_0000;
        unique case (s_axi_araddr)
          ADDR_MR1:    rdata_reg[MR_W-1:0] <= mr1_reg;
          ADDR_MR5:    rdata_reg[MR_W-1:0] <= mr5_reg;
          ADDR_STATUS: begin
            rdata_reg[ST_LEGAL_BIT] <= legalMode;
            rdata_reg[ST_RXON_BIT]  <= rxOn_reg;
            rdata_reg[ST_TXON_BIT]  <= rdInvOn;
            rdata_reg[ST_BEAT_LSB +: BEAT_W] <= beatIdx_reg;
          end
          default:     rresp_reg <= RESP_SLVERR;
        endcase
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Write pins are captured through two flip-flops before any decode.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqSync1_reg   <= '0;
      dqSync2_reg   <= '0;
      flagSync1_reg <= '1;
      flagSync2_reg <= '1;
      beatSync1_reg <= 1'b0;
      beatSync2_reg <= 1'b0;
    end else begin
      dqSync1_reg   <= dqIn;
      dqSync2_reg   <= dqSync1_reg;
      flagSync1_reg <= byteFlagIn_n;
      flagSync2_reg <= flagSync1_reg;
      beatSync1_reg <= wrBeatIn;
      beatSync2_reg <= beatSync1_reg;
    end
  end

  // Receiver enable: off when neither write function needs the flag.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxOn_reg <= 1'b0;
    end else begin
      rxOn_reg <= maskOn | wrInvOn;
    end
  end

  // Beat position inside the burst of eight, counted over write and read beats.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      beatIdx_reg <= '0;
    end else if (beatSync2_reg | coreRdValid) begin
      beatIdx_reg <= beatIdx_reg + 3'h1;
    end
  end

  // Per-lane write decode; each lane reads only its own flag.
  for (genvar ln = 0; ln < LANES; ln++) begin : g_wr_lane
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        wrData_reg[ln*BYTE_W +: BYTE_W] <= '0;
        wrByteEn_reg[ln]                <= 1'b0;
      end else if (beatSync2_reg) begin
        // A low flag inverts the byte only under write inversion.
        wrData_reg[ln*BYTE_W +: BYTE_W] <= (wrInvOn & ~flagSync2_reg[ln])
          ? ~dqSync2_reg[ln*BYTE_W +: BYTE_W] : dqSync2_reg[ln*BYTE_W +: BYTE_W];
        // A low flag drops the byte only under masking; otherwise the level is ignored.
        wrByteEn_reg[ln] <= ~(maskOn & ~flagSync2_reg[ln]);
      end
    end
  end

  // Write beat strobe to the core, one cycle per beat.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrValid_reg <= 1'b0;
    end else begin
      wrValid_reg <= beatSync2_reg;
    end
  end

  // Per-lane read encoder; the flag is the same beat's decision for that byte.
  for (genvar ln = 0; ln < LANES; ln++) begin : g_rd_lane
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        dqOut_reg[ln*BYTE_W +: BYTE_W] <= '0;
        flagOut_reg[ln]                <= 1'b1;
        flagOe_reg[ln]                 <= 1'b1;
      end else begin
        if (rdInvOn & needInvert(coreRdData[ln*BYTE_W +: BYTE_W])) begin
          dqOut_reg[ln*BYTE_W +: BYTE_W] <= ~coreRdData[ln*BYTE_W +: BYTE_W];
          flagOut_reg[ln]                <= 1'b0;
        end else begin
          dqOut_reg[ln*BYTE_W +: BYTE_W] <= coreRdData[ln*BYTE_W +: BYTE_W];
          flagOut_reg[ln]                <= 1'b1;
        end
        // Driver stays off without read inversion or under termination.
        flagOe_reg[ln] <= ~(coreRdValid & rdInvOn & ~termOn);
      end
    end
  end

  // Data pins are driven only on read beats.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dqOe_reg <= '1;
    end else begin
      dqOe_reg <= {DQ_W{~coreRdValid}};
    end
  end

  // The termination pair copies the strobe termination while enabled.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      termRtt_reg <= '0;
    end else begin
      termRtt_reg <= termOn ? dqsRtt : '0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = awready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign dqOut         = dqOut_reg;
  assign dqOe_n        = dqOe_reg;
  assign byteFlagOut_n = flagOut_reg;
  assign byteFlagOe_n  = flagOe_reg;
  assign flagRxOn      = rxOn_reg;
  assign termStrobeRtt = termRtt_reg;
  assign coreWrData    = wrData_reg;
  assign coreWrByteEn  = wrByteEn_reg;
  assign coreWrValid   = wrValid_reg;

  // Checks on the codec; all in the system clock domain.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_RD_INV_LOW: assert property (
    coreRdValid && rdInvOn && needInvert(coreRdData[BYTE_W-1:0])
    |=> !byteFlagOut_n[0] && !byteFlagOe_n[0] && dqOut[BYTE_W-1:0] == ~$past(coreRdData[BYTE_W-1:0]))
    else $error("low lane read byte not inverted");

  AST_RD_PLAIN_HIGH: assert property (
    coreRdValid && rdInvOn && !needInvert(coreRdData[DQ_W-1:BYTE_W])
    |=> byteFlagOut_n[1] && dqOut[DQ_W-1:BYTE_W] == $past(coreRdData[DQ_W-1:BYTE_W]))
    else $error("high lane read byte changed without need");

  AST_NO_DRIVE: assert property (
    !rdInvOn |=> byteFlagOe_n == 2'h3)
    else $error("flag driven with read inversion off");

  AST_MASK_DROP: assert property (
    beatSync2_reg && maskOn && !flagSync2_reg[1] |=> coreWrValid && !coreWrByteEn[1])
    else $error("masked byte was written");

  AST_WINV: assert property (
    beatSync2_reg && wrInvOn && !flagSync2_reg[0]
    |=> coreWrByteEn[0] == !$past(maskOn) && coreWrData[BYTE_W-1:0] == ~$past(dqSync2_reg[BYTE_W-1:0]))
    else $error("write byte not inverted");

  AST_RX_OFF: assert property (
    !maskOn && !wrInvOn ##1 beatSync2_reg && !maskOn && !wrInvOn
    |=> !flagRxOn && coreWrByteEn == 2'h3 && coreWrData == $past(dqSync2_reg))
    else $error("flag level used with receiver off");

  AST_TERM_HELD_OFF: assert property (
    !termOn && termStrobeRtt == '0)
    else $error("termination strobe became enabled");

  AST_WR_PIPE: assert property (
    $rose(wrBeatIn) |-> ##3 coreWrValid)
    else $error("write beat lost in capture path");

  AST_BRESP: assert property (
    s_axi_awready |=> s_axi_bvalid)
    else $error("write response missing");

  COV_RD_INV:   cover property (coreRdValid && rdInvOn ##1 !byteFlagOut_n[0]);
  COV_MASKED:   cover property (coreWrValid && coreWrByteEn != 2'h3);
  COV_WR_INV:   cover property (wrInvOn && beatSync2_reg && flagSync2_reg != 2'h3);
  COV_ILLEGAL:  cover property (!legalMode);

endmodule

// ### hw/mask_inv_pkg.sv
// Constants shared by the byte mask and inversion codec and its register slave.
package mask_inv_pkg;

  // Organisation of the data interface: two byte lanes, bursts of eight beats.
  localparam int LANES     = 2;
  localparam int BYTE_W    = 8;
  localparam int DQ_W      = LANES * BYTE_W;
  localparam int BURST_LEN = 8;

  // A byte with more zero bits than this is sent inverted on reads.
  localparam logic [3:0] ZERO_LIMIT = 4'h4;

  // Register byte addresses on the AXI4-Lite port.
  localparam int        ADDR_W     = 8;
  localparam logic [7:0] ADDR_MR1    = 8'h00;
  localparam logic [7:0] ADDR_MR5    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // Mode register images hold the low sixteen address bits of the mode command.
  localparam int MR_W = 16;

  // Field positions inside the first mode register image.
  localparam int MR1_TERM_BIT = 11;
  localparam int MR1_RTT_LSB  = 8;
  localparam int RTT_W        = 3;

  // Field positions inside the fifth mode register image.
  localparam int MR5_RDINV_BIT = 12;
  localparam int MR5_WRINV_BIT = 11;
  localparam int MR5_MASK_BIT  = 10;

  // Bits that software may change; the termination strobe bit is left out.
  localparam logic [15:0] MR1_WR_MASK = 16'hF7FF;
  localparam logic [15:0] MR5_WR_MASK = 16'hFFFF;
  localparam logic [15:0] MR_RESET    = 16'h0000;

  // Status register bit positions.
  localparam int ST_LEGAL_BIT = 0;
  localparam int ST_RXON_BIT  = 1;
  localparam int ST_TXON_BIT  = 2;
  localparam int ST_BEAT_LSB  = 4;
  localparam int BEAT_W       = 3;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
